//--- fpc_pkg.sv
// Shared constants and types for the operator front-panel control block.
// Assumes one 100 MHz clock; keys arrive raw from pushbutton pins.
package fpc_pkg;
  localparam int WORD_W = 16; // Display and data word width
  localparam int CLK_MHZ = 100; // Clock rate in MHz
  localparam int BLINK_HALF_MS = 250; // Run lamp blink half period in ms
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000; // Cycles per half period
  // Control key indices inside the control key vector
  localparam int K_LOAD = 0; // Loader key
  localparam int K_BLANK = 1; // blank_readout_key
  localparam int K_SHOW = 2; // show_word_key
  localparam int K_ENTER = 3; // Enter key
  localparam int K_VIEW = 4; // First of five view keys, in view enum order
  localparam int K_CODE = 9; // First of four code keys, weight 1 first
  localparam int K_CODE_CLR = 13; // Code clear key
  localparam int K_CODE_STEP = 14; // code_step_key
  localparam int K_INT = 15; // Panel interrupt key
  localparam int K_RESET = 16; // Processor reset key
  localparam int NKEY = 17; // Number of control keys
  // View targets, one lamp each
  typedef enum logic [2:0] {
    VIEW_MEM = 3'h0, VIEW_STATUS = 3'h1, VIEW_IR = 3'h2, VIEW_PC = 3'h3, VIEW_REG = 3'h4
  } fpc_view_e;
  // Run and step lamp state, Gray along step, blinking, steady
  typedef enum logic [1:0] {
    LAMP_STEP = 2'h0, LAMP_BLINK = 2'h1, LAMP_ON = 2'h3
  } fpc_lamp_e;
  // Memory access sequencer
  typedef enum logic [1:0] {
    MEM_IDLE = 2'h0, MEM_RD = 2'h1, MEM_WR = 2'h2
  } fpc_mem_e;
  // Status word field positions
  localparam int ST_KEY_LSB = 12; // Key register bits 15..12
  localparam int ST_CARRY = 11;
  localparam int ST_SIGN = 10;
  localparam int ST_ONES = 9;
  localparam int ST_OVF = 8;
  localparam int ST_SHIFT_LSB = 3; // Shift counter bits 7..3
  localparam int ST_ZERO = 2;
  localparam int ST_SUPER = 1;
  localparam int SIGN_BIT = 15; // Sign of the displayed word
  // Selection codes with fixed meaning
  localparam logic [3:0] CODE_IR = 4'h8;
  localparam logic [3:0] CODE_ZERO = 4'hb;
  localparam logic [3:0] CODE_ONES = 4'hc;
  localparam logic [15:0] INT_VECTOR = 16'h0000; // Panel interrupt target address
  // Reset values
  localparam logic [15:0] DISP_RST = 16'h0000;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic CTRL_EN_RST = 1'b1;
  // APB map, byte addresses
  localparam logic [11:0] A_CTRL = 12'h000; // bit0 panel key enable
  localparam logic [11:0] A_STATE = 12'h004; // View, code, lamps, sequencer
  localparam logic [11:0] A_WORD = 12'h008; // Display register
  localparam int SF_VIEW = 0; // State register field positions
  localparam int SF_CODE = 5;
  localparam int SF_LAMP = 9;
  localparam int SF_MEM = 11;
endpackage

//--- fpc_keyedge.sv
// Pushbutton synchroniser and press detector, one lane per key.
// Assumes keys are clean levels from pins, high while held.
`timescale 1ns/100ps
module fpc_keyedge #(
  parameter int N = 1 // Number of keys
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [N-1:0] keys_raw, // Raw key levels from pins
  output logic [N-1:0] press // One-cycle pulse per press
);
  typedef struct packed {
    logic [N-1:0] s1; // First synchroniser stage, read by s2 only
    logic [N-1:0] s2; // Second stage
    logic [N-1:0] prev; // Previous synchronised level
  } fpc_ke_s;
  fpc_ke_s q, d;

  // Shift levels through; a press is a rising synchronised level
  always_comb begin
    d = q;
    d.s1 = keys_raw;
    d.s2 = q.s1;
    d.prev = q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Holding a key yields one pulse only
  assign press = q.s2 & ~q.prev;
endmodule

//--- fpc_panel.sv
// Front-panel control: display register, view selector, register code, memory examine/deposit.
// Assumes core inputs share pclk; key pins are asynchronous; memory answers with mem_ack.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
// How it works
// - Loader key lights run lamp, starts loader
// - Sixteen-bit display register drives readout lamps
// - Blank key zeroes the display register
// - Entry keys only set bits
// - Top bit shows the sign
// - Show key in memory view reads word
// - Enter key in memory view writes word
// - Exactly one of five views selected
// - Status upper byte: key bits, alu flags
// - Status lower byte: shift count, zero, supervisor
// - Instruction view shows it unless running
// - Edits in instruction view copied to it
// - Counter view shows it unless running, takes edits
// - Four-bit code picks register to view
// - Code keys set bits and lamps
// - Chosen register shown and takes edits
// - Code clear zeroes; step key increments
// - Code 1000 shows instruction register
// - Codes 1011, 1100 constant, writes ignored
// - Interrupt key acts only when running
// - Reset key halts, step lamp, clears overflow
// - Each show press in memory view advances program counter
// - Reset: step, blank word, counter view
module fpc_panel #(
  parameter int BLINK_HALF_CYC = fpc_pkg::BLINK_HALF_CYC // Run lamp blink half period
) (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [fpc_pkg::NKEY-1:0] ctl_keys, // Control pushbuttons, raw
  input wire logic [15:0] entry_keys, // Entry pushbuttons, raw
  output logic [15:0] lamp_word, // Readout lamps
  output logic [4:0] view_lamps, // One lamp per view
  output logic [3:0] code_lamps, // Selection code lamps, also code to core
  output logic run_lamp, // Run lamp, blinks when halted in run mode
  output logic step_lamp, // Step lamp
  input wire logic [15:0] ir_in, // Instruction register value
  input wire logic [15:0] pc_in, // Program counter value
  input wire logic [15:0] reg_rdata, // Register picked by code_lamps
  input wire logic [3:0] key_word_bits, // Key register bits 15..12
  input wire logic alu_carry_flag, // ALU carry
  input wire logic alu_sign_flag, // ALU sign
  input wire logic alu_all_ones_flag, // ALU output all ones
  input wire logic alu_overflow_flag, // ALU overflow
  input wire logic [4:0] shift_count_bits, // Shift counter
  input wire logic alu_zero_flag, // ALU output zero
  input wire logic supervisor_flag, // Supervisor mode
  input wire logic core_start, // Core started running, pulse
  input wire logic core_halt, // Core halted in run mode, pulse
  input wire logic core_stop, // Core entered step mode, pulse
  output logic [15:0] wr_data, // Data for core register writes
  output logic ir_wr, // Write wr_data to instruction register, pulse
  output logic pc_wr, // Write wr_data to program counter, pulse
  output logic reg_wr, // Write wr_data to register code_lamps, pulse
  output logic pc_inc, // Advance program counter, pulse
  output logic cpu_int, // Interrupt request, pulse
  output logic [15:0] int_addr, // Interrupt target address
  output logic cpu_load, // Start loader copy, pulse
  output logic cpu_reset, // Halt and initialise core and I/O, pulse
  output logic ovf_clear, // Clear overflow flag, pulse
  output logic mem_rd, // Memory read request, held to ack
  output logic mem_wr, // Memory write request, held to ack
  output logic [15:0] mem_addr, // Memory address
  output logic [15:0] mem_wdata, // Memory write data
  input wire logic [15:0] mem_rdata, // Memory read data, valid with ack
  input wire logic mem_ack // Memory done, pulse
);
  typedef struct packed {
    logic [15:0] disp; // Display register
    fpc_pkg::fpc_view_e view; // Current view
    logic [3:0] code; // Selection code
    fpc_pkg::fpc_lamp_e lamp; // Run/step lamp state
    logic blink; // Blink phase
    logic [31:0] bcnt; // Blink divider
    fpc_pkg::fpc_mem_e mem; // Memory sequencer
    logic [15:0] maddr; // Latched memory address
    logic refresh; // Reload display from target next cycle
    logic edit; // Display was edited last cycle
    logic ir_wr, pc_wr, reg_wr, pc_inc; // Core write pulses
    logic cpu_int, cpu_load, cpu_rst, ovf_clr; // Core control pulses
    logic en; // Panel keys enabled
    logic [31:0] prdata; // APB read data
  } fpc_state_s;
  fpc_state_s q, d;

  logic [fpc_pkg::NKEY-1:0] press; // Control key pulses
  logic [15:0] epress; // Entry key pulses
  logic [fpc_pkg::NKEY-1:0] p; // Gated control key pulses
  logic [15:0] ep; // Gated entry key pulses
  logic [15:0] status_word; // Assembled status view
  logic apb_setup; // APB setup cycle
  logic apb_wr; // APB write takes effect
  logic addr_ok; // Address is mapped

  // All keys come from pins, so one synchronising edge detector covers them
  fpc_keyedge #(.N(fpc_pkg::NKEY + 16)) u_keys (
    .pclk(pclk),
    .presetn(presetn),
    .keys_raw({entry_keys, ctl_keys}),
    .press({epress, press})
  );

  assign p = q.en ? press : '0;
  assign ep = q.en ? epress : '0;

  // Status layout
  always_comb begin
    status_word = '0;
    status_word[fpc_pkg::ST_KEY_LSB +: 4] = key_word_bits;
    status_word[fpc_pkg::ST_CARRY] = alu_carry_flag;
    status_word[fpc_pkg::ST_SIGN] = alu_sign_flag;
    status_word[fpc_pkg::ST_ONES] = alu_all_ones_flag;
    status_word[fpc_pkg::ST_OVF] = alu_overflow_flag;
    status_word[fpc_pkg::ST_SHIFT_LSB +: 5] = shift_count_bits;
    status_word[fpc_pkg::ST_ZERO] = alu_zero_flag;
    status_word[fpc_pkg::ST_SUPER] = supervisor_flag;
  end

  // APB decode; no wait states, so the access phase is the answer
  assign apb_setup = psel && !penable;
  assign addr_ok = (paddr == fpc_pkg::A_CTRL) || (paddr == fpc_pkg::A_STATE) || (paddr == fpc_pkg::A_WORD);
  assign apb_wr = psel && penable && pwrite && (paddr == fpc_pkg::A_CTRL);

  // Next state of the whole panel
  always_comb begin
    d = q;
    d.refresh = 1'b0;
    d.edit = 1'b0;
    d.ir_wr = 1'b0;
    d.pc_wr = 1'b0;
    d.reg_wr = 1'b0;
    d.pc_inc = 1'b0;
    d.cpu_int = 1'b0;
    d.cpu_load = 1'b0;
    d.cpu_rst = 1'b0;
    d.ovf_clr = 1'b0;
    // Blink divider, one enable per half period
    if (q.bcnt >= 32'(BLINK_HALF_CYC - 1)) begin
      d.bcnt = '0;
      d.blink = ~q.blink;
    end else begin
      d.bcnt = q.bcnt + 32'h1;
    end
    // Core mode reports; panel keys below take precedence
    if (core_stop) begin
      d.lamp = fpc_pkg::LAMP_STEP;
    end else if (core_start) begin
      d.lamp = fpc_pkg::LAMP_ON;
    end else if (core_halt) begin
      d.lamp = fpc_pkg::LAMP_BLINK;
    end
    if (p[fpc_pkg::K_LOAD]) begin
      d.lamp = fpc_pkg::LAMP_ON;
      d.cpu_load = 1'b1;
    end
    // Reset key wins over loader: halt leaves step mode
    if (p[fpc_pkg::K_RESET]) begin
      d.lamp = fpc_pkg::LAMP_STEP;
      d.cpu_rst = 1'b1;
      d.ovf_clr = 1'b1;
    end
    // Interrupt only while steadily running
    if (p[fpc_pkg::K_INT] && q.lamp == fpc_pkg::LAMP_ON) begin
      d.cpu_int = 1'b1;
    end
    // View keys: lowest index wins if several land together
    for (int i = 4; i >= 0; i--) begin
      if (p[fpc_pkg::K_VIEW + i]) begin
        d.view = fpc_pkg::fpc_view_e'(3'(i));
        d.refresh = 1'b1;
      end
    end
    // Selection code: clear, then step, then set bits
    if (p[fpc_pkg::K_CODE_CLR]) begin
      d.code = '0;
    end else if (p[fpc_pkg::K_CODE_STEP]) begin
      d.code = q.code + 4'h1;
    end
    d.code = d.code | p[fpc_pkg::K_CODE +: 4];
    if (d.code != q.code && q.view == fpc_pkg::VIEW_REG) begin
      d.refresh = 1'b1;
    end
    // Reload display from the newly chosen target
    if (q.refresh) begin
      case (q.view)
        fpc_pkg::VIEW_IR: if (q.lamp != fpc_pkg::LAMP_ON) d.disp = ir_in;
        fpc_pkg::VIEW_PC: if (q.lamp != fpc_pkg::LAMP_ON) d.disp = pc_in;
        fpc_pkg::VIEW_REG: begin
          if (q.code == fpc_pkg::CODE_IR) begin
            d.disp = ir_in;
          end else if (q.code == fpc_pkg::CODE_ZERO) begin
            d.disp = '0;
          end else if (q.code == fpc_pkg::CODE_ONES) begin
            d.disp = '1;
          end else begin
            d.disp = reg_rdata;
          end
        end
        default: ;
      endcase
    end
    // Status view tracks the core live
    if (q.view == fpc_pkg::VIEW_STATUS) begin
      d.disp = status_word;
    end
    // Operator edits: clear first, entry keys then only set bits
    if (p[fpc_pkg::K_BLANK]) begin
      d.disp = '0;
      d.edit = 1'b1;
    end
    if (|ep) begin
      d.disp = d.disp | ep;
      d.edit = 1'b1;
    end
    // Copy an edit to the viewed target one cycle later
    if (q.edit) begin
      case (q.view)
        fpc_pkg::VIEW_IR: d.ir_wr = 1'b1;
        fpc_pkg::VIEW_PC: d.pc_wr = 1'b1;
        fpc_pkg::VIEW_REG: begin
          if (q.code == fpc_pkg::CODE_IR) begin
            d.ir_wr = 1'b1;
          end else if (q.code != fpc_pkg::CODE_ZERO && q.code != fpc_pkg::CODE_ONES) begin
            d.reg_wr = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Memory examine and deposit at the program counter
    case (q.mem)
      fpc_pkg::MEM_IDLE: begin
        if (q.view == fpc_pkg::VIEW_MEM && p[fpc_pkg::K_SHOW]) begin
          d.mem = fpc_pkg::MEM_RD;
          d.maddr = pc_in;
        end else if (q.view == fpc_pkg::VIEW_MEM && p[fpc_pkg::K_ENTER]) begin
          d.mem = fpc_pkg::MEM_WR;
          d.maddr = pc_in;
        end
      end
      fpc_pkg::MEM_RD: begin
        if (mem_ack) begin
          d.disp = mem_rdata;
          d.pc_inc = 1'b1;
          d.mem = fpc_pkg::MEM_IDLE;
        end
      end
      fpc_pkg::MEM_WR: begin
        if (mem_ack) begin
          d.pc_inc = 1'b1; // Deposit also steps on
          d.mem = fpc_pkg::MEM_IDLE;
        end
      end
      default: d.mem = fpc_pkg::MEM_IDLE;
    endcase
    // Register bus
    if (apb_wr) begin
      d.en = pwdata[0];
    end
    if (apb_setup) begin
      case (paddr)
        fpc_pkg::A_CTRL: d.prdata = {31'h0, q.en};
        fpc_pkg::A_STATE: d.prdata = {19'h0, q.mem, q.lamp, q.code, view_lamps};
        fpc_pkg::A_WORD: d.prdata = {16'h0, q.disp};
        default: d.prdata = 32'h0;
      endcase
    end
  end

  // State register; power-on leaves step mode, blank word, counter view
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.disp <= fpc_pkg::DISP_RST;
      q.code <= fpc_pkg::CODE_RST;
      q.view <= fpc_pkg::VIEW_PC;
      q.lamp <= fpc_pkg::LAMP_STEP;
      q.mem <= fpc_pkg::MEM_IDLE;
      q.en <= fpc_pkg::CTRL_EN_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign lamp_word = q.disp;
  assign view_lamps = 5'(5'h1 << q.view);
  assign code_lamps = q.code;
  assign run_lamp = (q.lamp == fpc_pkg::LAMP_ON) || (q.lamp == fpc_pkg::LAMP_BLINK && q.blink);
  assign step_lamp = (q.lamp == fpc_pkg::LAMP_STEP);
  assign wr_data = q.disp;
  assign ir_wr = q.ir_wr;
  assign pc_wr = q.pc_wr;
  assign reg_wr = q.reg_wr;
  assign pc_inc = q.pc_inc;
  assign cpu_int = q.cpu_int;
  assign int_addr = fpc_pkg::INT_VECTOR;
  assign cpu_load = q.cpu_load;
  assign cpu_reset = q.cpu_rst;
  assign ovf_clear = q.ovf_clr;
  assign mem_rd = (q.mem == fpc_pkg::MEM_RD);
  assign mem_wr = (q.mem == fpc_pkg::MEM_WR);
  assign mem_addr = q.maddr;
  assign mem_wdata = q.disp;
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_go;
    q.mem == fpc_pkg::MEM_IDLE && q.view == fpc_pkg::VIEW_MEM && p[fpc_pkg::K_SHOW];
  endsequence
  sequence s_rd_done;
    mem_rd && mem_ack;
  endsequence

  chk_key_single: assert property (press != '0 |=> (press & $past(press)) == '0)
    else $error("key pulse lasted two cycles");
  chk_blank_zero: assert property (p[fpc_pkg::K_BLANK] && ep == '0 && q.view != fpc_pkg::VIEW_STATUS
    && !mem_rd |=> lamp_word == 16'h0)
    else $error("blank key left bits set");
  chk_entry_sets: assert property (ep != '0 && !mem_rd && q.view != fpc_pkg::VIEW_STATUS
    |=> (lamp_word & $past(ep)) == $past(ep))
    else $error("entry key did not set its bit");
  chk_view_onehot: assert property ($onehot(view_lamps))
    else $error("view lamps not one-hot");
  chk_status_word: assert property (q.view == fpc_pkg::VIEW_STATUS && !p[fpc_pkg::K_BLANK] && ep == '0
    && !mem_rd |=> lamp_word == $past(status_word))
    else $error("status view mismatch");
  chk_ir_copy: assert property (q.edit && q.view == fpc_pkg::VIEW_IR |=> ir_wr && !reg_wr)
    else $error("edit not copied to instruction register");
  chk_const_nowrite: assert property (q.edit && q.view == fpc_pkg::VIEW_REG
    && (q.code == fpc_pkg::CODE_ZERO || q.code == fpc_pkg::CODE_ONES) |=> !reg_wr && !ir_wr)
    else $error("constant register written");
  chk_int_gate: assert property (p[fpc_pkg::K_INT] |=> cpu_int == ($past(q.lamp) == fpc_pkg::LAMP_ON))
    else $error("interrupt key gating wrong");
  chk_reset_key: assert property (p[fpc_pkg::K_RESET] |=> step_lamp && !run_lamp && ovf_clear && cpu_reset)
    else $error("reset key effects missing");
  chk_load_key: assert property (p[fpc_pkg::K_LOAD] && !p[fpc_pkg::K_RESET] |=> run_lamp && cpu_load)
    else $error("loader key did not start");
  chk_mem_read: assert property (s_rd_go |=> mem_rd)
    else $error("show key did not start read");
  chk_read_inc: assert property (s_rd_done |=> pc_inc && lamp_word == $past(mem_rdata) && !mem_rd)
    else $error("read did not show word and advance");
  chk_code_step: assert property (p[fpc_pkg::K_CODE_STEP] && !p[fpc_pkg::K_CODE_CLR]
    && p[fpc_pkg::K_CODE +: 4] == 4'h0 |=> code_lamps == $past(code_lamps) + 4'h1)
    else $error("code step wrong");
endmodule

//--- fpc_core_mdl.sv
// Behavioural core and small memory on the far side of the front panel.
// Assumes one-cycle panel pulses and memory requests held until ack.
`timescale 1ns/100ps
module fpc_core_mdl (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [2:0] mem_dly, // Wait cycles before ack
  input wire logic [3:0] code_lamps, // Register picked by the panel
  input wire logic [15:0] wr_data, // Edit value
  input wire logic ir_wr, // Load instruction register
  input wire logic pc_wr, // Load program counter
  input wire logic reg_wr, // Load picked register
  input wire logic pc_inc, // Advance program counter
  input wire logic mem_rd, // Read request
  input wire logic mem_wr, // Write request
  input wire logic [15:0] mem_addr, // Access address
  input wire logic [15:0] mem_wdata, // Write word
  output logic [15:0] ir_in, // Instruction register
  output logic [15:0] pc_in, // Program counter
  output logic [15:0] reg_rdata, // Picked register
  output logic [15:0] mem_rdata, // Read word
  output logic mem_ack // Access done, one cycle
);
  logic [15:0] regs [16]; // One register per code
  logic [15:0] mem [256]; // Low memory only, address wraps
  logic [2:0] wait_q; // Cycles spent on the open access
  assign reg_rdata = regs[code_lamps];
  // Core state and memory; a slow ack proves the panel holds its request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_in <= 16'h0a5a;
      pc_in <= 16'h0010;
      wait_q <= 3'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      for (int i = 0; i < 256; i++) mem[i] <= {8'h5a, i[7:0]};
      for (int i = 0; i < 16; i++) regs[i] <= 16'h1100 + 16'(i);
    end else begin
      mem_ack <= 1'b0;
      // An idle bus never keeps showing the last word
      mem_rdata <= ~mem_rdata;
      if (ir_wr) ir_in <= wr_data;
      if (pc_wr) pc_in <= wr_data;
      else if (pc_inc) pc_in <= pc_in + 16'h0001;
      if (reg_wr) regs[code_lamps] <= wr_data;
      if ((mem_rd || mem_wr) && !mem_ack) begin
        wait_q <= wait_q + 3'h1;
        if (wait_q >= mem_dly) begin
          wait_q <= 3'h0;
          mem_ack <= 1'b1;
          if (mem_rd) mem_rdata <= mem[mem_addr[7:0]];
          if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
        end
      end
    end
  end
endmodule

//--- tb_front_panel_control.sv
// Self-checking bench: panel, core model, APB master and pushbutton driver.
// Assumes a key acts within four edges of its press; inputs change on pclk rising edges.
`timescale 1ns/100ps
module tb_front_panel_control;
  localparam int KV = fpc_pkg::K_VIEW; // First view key
  localparam int KC = fpc_pkg::K_CODE; // First code key
  localparam int E = 17; // Entry key i is press index E + i
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000; // APB address
  logic [31:0] pwdata = 32'h0, prdata, rd; // APB data, last read
  logic [fpc_pkg::NKEY-1:0] ctl_keys = '0; // Control keys
  logic [15:0] entry_keys = 16'h0000, lamp_word, ir_in, pc_in, reg_rdata, wr_data, int_addr;
  logic [15:0] mem_addr, mem_wdata, mem_rdata; // Memory side
  logic [4:0] view_lamps, shift_count_bits = 5'h00; // Lamps, status shift count
  logic [3:0] code_lamps, key_word_bits = 4'h0; // Code lamps, status key bits
  logic run_lamp, step_lamp, ir_wr, pc_wr, reg_wr, pc_inc, cpu_int, cpu_load, cpu_reset, ovf_clear;
  logic alu_carry_flag = 1'b0, alu_sign_flag = 1'b0, alu_all_ones_flag = 1'b0, alu_overflow_flag = 1'b0;
  logic alu_zero_flag = 1'b0, supervisor_flag = 1'b0, mem_rd, mem_wr, mem_ack;
  logic core_start = 1'b0, core_halt = 1'b0, core_stop = 1'b0; // Core mode pulses
  logic [2:0] mem_dly = 3'h0; // Model ack delay
  int n_mismatch, compares, cyc, n_int, n_load, n_rst, n_ovf; // Counters
  typedef struct {logic [3:0] code; logic [15:0] exp;} fpc_row_s;
  // Selection code rows beside the word each should show
  fpc_row_s rows [6] = '{'{4'h0, 16'h1100}, '{4'h5, 16'h1105}, '{4'h8, 16'h0a5a},
    '{4'hb, 16'h0000}, '{4'hc, 16'hffff}, '{4'hf, 16'h110f}};
  logic [15:0] pats [2] = '{16'haaac, 16'h5552}; // Status patterns, bit 0 clear
  fpc_panel #(.BLINK_HALF_CYC(4)) fpc_panel_i (.*);
  fpc_core_mdl fpc_core_mdl_i (.*);
  always #5 pclk = ~pclk;
  // Pulse counters; an interrupt only counts with the vector at zero
  always @(posedge pclk) begin
    cyc++;
    if (cpu_int === 1'b1 && int_addr === 16'h0000) n_int++;
    if (cpu_load === 1'b1) n_load++;
    if (cpu_reset === 1'b1) n_rst++;
    if (ovf_clear === 1'b1) n_ovf++;
    if (cyc == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds a key six cycles: a long press must still act once
  task automatic press(input int i);
    if (i < E) ctl_keys[i] <= 1'b1;
    else entry_keys[i-E] <= 1'b1;
    repeat (6) @(posedge pclk);
    ctl_keys <= '0;
    entry_keys <= 16'h0000;
    repeat (8) @(posedge pclk);
  endtask
  task automatic view(input int v);
    press(KV + v);
    chk("view_lamps", 16'h1 << v, 16'(view_lamps));
  endtask
  task automatic core(input logic [2:0] v);
    {core_stop, core_halt, core_start} <= v;
    @(posedge pclk);
    {core_stop, core_halt, core_start} <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask
  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("lamp_word", 16'h0000, lamp_word);
    chk("view_lamps", 16'h0008, 16'(view_lamps));
    chk("code_lamps", 16'h0000, 16'(code_lamps));
    chk("step_run", 16'h0002, 16'({step_lamp, run_lamp}));
    apb(1'b0, fpc_pkg::A_CTRL, 32'h0);
    chk("ctrl", 16'h0001, rd[15:0]);
    // Power-on state word: idle sequencer, step lamp, code zero, counter view lamp
    apb(1'b0, fpc_pkg::A_STATE, 32'h0);
    chk("state", 16'h0008, rd[15:0]);
    apb(1'b0, 12'h00c, 32'h0);
    chk("pslverr", 16'h0001, 16'(err));
    view(4);
    // Register view table, code entered from clear each row
    foreach (rows[r]) begin
      press(fpc_pkg::K_CODE_CLR);
      for (int b = 0; b < 4; b++) if (rows[r].code[b]) press(KC + b);
      chk("code_lamps", 16'(rows[r].code), 16'(code_lamps));
      chk("reg_view", rows[r].exp, lamp_word);
    end
    // Step from code f wraps to code 0
    press(fpc_pkg::K_CODE_STEP);
    chk("code_step", 16'h0000, 16'(code_lamps));
    chk("reg_view", 16'h1100, lamp_word);
    press(fpc_pkg::K_BLANK);
    chk("blank", 16'h0000, lamp_word);
    press(E + 3);
    press(E + 15);
    press(E + 3);
    chk("entry", 16'h8008, lamp_word);
    chk("reg_edit", 16'h8008, fpc_core_mdl_i.regs[0]);
    press(KC + 0);
    press(KC + 1);
    press(KC + 3);
    press(E + 0);
    chk("const_reg", 16'h110b, fpc_core_mdl_i.regs[11]);
    view(2);
    chk("ir_view", 16'h0a5a, lamp_word);
    press(fpc_pkg::K_BLANK);
    press(E + 2);
    chk("ir_edit", 16'h0004, ir_in);
    view(3);
    chk("pc_view", 16'h0010, lamp_word);
    press(fpc_pkg::K_BLANK);
    press(E + 5);
    chk("pc_edit", 16'h0020, pc_in);
    // Examine with a slow then a prompt memory, then deposit
    mem_dly <= 3'h3;
    view(0);
    press(fpc_pkg::K_SHOW);
    chk("show", 16'h5a20, lamp_word);
    chk("pc_adv", 16'h0021, pc_in);
    mem_dly <= 3'h0;
    press(fpc_pkg::K_SHOW);
    chk("show", 16'h5a21, lamp_word);
    press(fpc_pkg::K_ENTER);
    chk("enter", 16'h5a21, fpc_core_mdl_i.mem[34]);
    apb(1'b1, fpc_pkg::A_CTRL, 32'h0);
    press(fpc_pkg::K_BLANK);
    chk("keys_off", 16'h5a21, lamp_word);
    apb(1'b0, fpc_pkg::A_WORD, 32'h0);
    chk("word_reg", 16'h5a21, rd[15:0]);
    apb(1'b1, fpc_pkg::A_CTRL, 32'h1);
    view(1);
    foreach (pats[p]) begin
      {key_word_bits, alu_carry_flag, alu_sign_flag, alu_all_ones_flag, alu_overflow_flag,
        shift_count_bits, alu_zero_flag, supervisor_flag} <= pats[p][15:1];
      repeat (3) @(posedge pclk);
      chk("status", {pats[p][15:1], 1'b0}, lamp_word);
    end
    // Interrupt counts only while running, not in step or halted
    press(fpc_pkg::K_INT);
    core(3'h1);
    press(fpc_pkg::K_INT);
    core(3'h2);
    press(fpc_pkg::K_INT);
    chk("int_count", 16'h0001, 16'(n_int));
    core(3'h1);
    press(fpc_pkg::K_RESET);
    chk("reset_pulse", 16'h0001, 16'(n_rst));
    chk("ovf_clear", 16'h0001, 16'(n_ovf));
    chk("step_run", 16'h0002, 16'({step_lamp, run_lamp}));
    press(fpc_pkg::K_LOAD);
    chk("load_pulse", 16'h0001, 16'(n_load));
    chk("run_lamp", 16'h0001, 16'(run_lamp));
    // A reset in mid-run must bring back the power-on panel state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("rst_word", 16'h0000, lamp_word);
    chk("rst_view", 16'h0008, 16'(view_lamps));
    chk("rst_code", 16'h0000, 16'(code_lamps));
    chk("rst_step_run", 16'h0002, 16'({step_lamp, run_lamp}));
    report_and_stop();
  end
endmodule
